// ---- btcc_pkg.sv ----
package btcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] ALARM_OFFSET = 8'h04;
  localparam logic [7:0] TIME_OFFSET = 8'h08;
  localparam logic [7:0] DATE_OFFSET = 8'h0c;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int TRIM_LSB = 16;
  localparam int TRIM_MSB = 25;
  localparam int ENABLE_BIT = 15;
  localparam int IDLE_HALT_BIT = 13;
  localparam int SRC_SEL_BIT = 7;
  localparam int RUNNING_BIT = 6;
  localparam int UNLOCK_BIT = 3;
  localparam int WARN_BIT = 2;
  localparam int HALF_BIT = 1;
  localparam int PIN_OE_BIT = 0;

  // Alarm register fields
  localparam int ARM_BIT = 15;
  localparam int CHIME_BIT = 14;
  localparam int PULSE_BIT = 13;
  localparam int ALARM_SYNC_BIT = 12;
  localparam int INTERVAL_LSB = 8;
  localparam int INTERVAL_MSB = 11;

  // Time and date fields (low bit of each two-digit field)
  localparam int HOUR_LSB = 24;
  localparam int MIN_LSB = 16;
  localparam int SEC_LSB = 8;
  localparam int YEAR_LSB = 24;
  localparam int MONTH_LSB = 16;
  localparam int DAY_LSB = 8;
  localparam int WDAY_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Alarm interval codes
  localparam logic [3:0] INT_HALF = 4'h0;
  localparam logic [3:0] INT_SEC = 4'h1;
  localparam logic [3:0] INT_TEN_SEC = 4'h2;
  localparam logic [3:0] INT_MIN = 4'h3;
  localparam logic [3:0] INT_TEN_MIN = 4'h4;
  localparam logic [3:0] INT_HOUR = 4'h5;
  localparam logic [3:0] INT_DAY = 4'h6;
  localparam logic [3:0] INT_WEEK = 4'h7;
  localparam logic [3:0] INT_MONTH = 4'h8;
  localparam logic [3:0] INT_YEAR = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // BCD limits and reset values
  localparam logic [3:0] DIGIT_NINE = 4'h9;
  localparam logic [7:0] ZERO_BCD = 8'h00;
  localparam logic [7:0] ONE_BCD = 8'h01;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] WDAY_MAX = 8'h06;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] FEB = 8'h02;
  localparam logic [7:0] APR = 8'h04;
  localparam logic [7:0] JUN = 8'h06;
  localparam logic [7:0] SEP = 8'h09;
  localparam logic [7:0] NOV = 8'h11;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [7:0] REPEAT_WRAP = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Counts: 16384 crystal pulses per half second
  localparam logic [15:0] HALF_TERMINAL = 16'h3fff;
  localparam logic [15:0] WARN_WINDOW = 16'h0020;
  localparam logic [15:0] WARN_START = HALF_TERMINAL - WARN_WINDOW;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CRYSTAL_TIMEOUT_NS = 100000;
  localparam int CRYSTAL_TIMEOUT_CYCLES = CRYSTAL_TIMEOUT_NS / CLK_PERIOD_NS;

endpackage

// ---- btcc_sync3.sv ----
module btcc_sync3 (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic level,
  output logic rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } btcc_sync_type;

  btcc_sync_type s;
  btcc_sync_type next_s;

  // A change counts once the second and third stage agree
  always_comb begin
    next_s = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3) begin
      next_s.level = s.s3;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;
  assign rise = (s.s2 == s.s3) && s.s3 && !s.level;

endmodule

// ---- btcc_bcd_field.sv ----
module btcc_bcd_field #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic inc,
  input wire logic load,
  input wire logic [7:0] load_value,
  input wire logic [7:0] min_value,
  input wire logic [7:0] max_value,
  output logic [7:0] value,
  output logic carry
);

  typedef struct packed {
    logic [7:0] value;
  } btcc_field_type;

  btcc_field_type s;
  btcc_field_type next_s;

  // Two BCD digits; a load from software wins over a count
  always_comb begin
    next_s = s;
    if (load) begin
      next_s.value = load_value;
    end else if (inc) begin
      if (s.value == max_value) begin
        next_s.value = min_value;
      end else if (s.value[3:0] == btcc_pkg::DIGIT_NINE) begin
        next_s.value = {s.value[7:4] + 4'h1, 4'h0};
      end else begin
        next_s.value = {s.value[7:4], s.value[3:0] + 4'h1};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s.value <= RESET_VALUE;
    end else begin
      s <= next_s;
    end
  end

  assign value = s.value;
  assign carry = inc && !load && (s.value == max_value);

endmodule

// ---- btcc_timekeeper.sv ----
// The AHB-Lite slave port and the register offsets were decided locally.
module btcc_timekeeper #(
  parameter int CLOCK_TIMEOUT_CYCLES = btcc_pkg::CRYSTAL_TIMEOUT_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sys_reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic crystal_in,
  input wire logic system_unlock,
  input wire logic cpu_idle,
  output logic timekeeper_pin,
  output logic timekeeper_pin_oe
);

  typedef struct packed {
    logic enable;
    logic idle_halt;
    logic src_sel;
    logic unlock;
    logic pin_oe_bit;
    logic [9:0] trim;
    logic arm;
    logic chime;
    logic pulse;
    logic [3:0] interval;
    logic [7:0] repeat_count;
    logic [15:0] prescaler;
    logic half_phase;
    logic [15:0] idle_count;
    logic running;
    logic pending;
    logic write;
    logic applied;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic pin;
    logic pin_drive;
  } btcc_state_type;

  btcc_state_type s;
  btcc_state_type next_s;

  logic crystal_level;
  logic crystal_rise;
  logic [7:0] sec;
  logic [7:0] min;
  logic [7:0] hour;
  logic [7:0] wday;
  logic [7:0] day;
  logic [7:0] month;
  logic [7:0] year;
  logic sec_carry;
  logic min_carry;
  logic hour_carry;
  logic day_carry;
  logic month_carry;
  logic gated;
  logic accept;
  logic wr_go;
  logic wr_ctrl;
  logic wr_alarm;
  logic wr_time;
  logic wr_date;
  logic run_tick;
  logic half_tick;
  logic sec_tick;
  logic warn;
  logic leap;
  logic [7:0] day_max;
  logic [15:0] trim_ext;
  logic interval_hit;
  logic alarm_event;

  ////////////////////////////////////////////////////////////////////////////
  // Crystal input and time fields

  btcc_sync3 u_crystal (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(crystal_in),
    .level(crystal_level),
    .rise(crystal_rise)
  );

  btcc_bcd_field #(.RESET_VALUE(btcc_pkg::ZERO_BCD)) u_sec (
    .hclk(hclk), .hresetn(hresetn), .inc(sec_tick), .load(wr_time),
    .load_value(hwdata[btcc_pkg::SEC_LSB +: 8]), .min_value(btcc_pkg::ZERO_BCD),
    .max_value(btcc_pkg::SEC_MAX), .value(sec), .carry(sec_carry)
  );
  btcc_bcd_field #(.RESET_VALUE(btcc_pkg::ZERO_BCD)) u_min (
    .hclk(hclk), .hresetn(hresetn), .inc(sec_carry), .load(wr_time),
    .load_value(hwdata[btcc_pkg::MIN_LSB +: 8]), .min_value(btcc_pkg::ZERO_BCD),
    .max_value(btcc_pkg::SEC_MAX), .value(min), .carry(min_carry)
  );
  btcc_bcd_field #(.RESET_VALUE(btcc_pkg::ZERO_BCD)) u_hour (
    .hclk(hclk), .hresetn(hresetn), .inc(min_carry), .load(wr_time),
    .load_value(hwdata[btcc_pkg::HOUR_LSB +: 8]), .min_value(btcc_pkg::ZERO_BCD),
    .max_value(btcc_pkg::HOUR_MAX), .value(hour), .carry(hour_carry)
  );

  // calendar with years 00 to 99
  btcc_bcd_field #(.RESET_VALUE(btcc_pkg::ZERO_BCD)) u_wday (
    .hclk(hclk), .hresetn(hresetn), .inc(hour_carry), .load(wr_date),
    .load_value(hwdata[btcc_pkg::WDAY_LSB +: 8]), .min_value(btcc_pkg::ZERO_BCD),
    .max_value(btcc_pkg::WDAY_MAX), .value(wday), .carry()
  );
  btcc_bcd_field #(.RESET_VALUE(btcc_pkg::ONE_BCD)) u_day (
    .hclk(hclk), .hresetn(hresetn), .inc(hour_carry), .load(wr_date),
    .load_value(hwdata[btcc_pkg::DAY_LSB +: 8]), .min_value(btcc_pkg::ONE_BCD),
    .max_value(day_max), .value(day), .carry(day_carry)
  );
  btcc_bcd_field #(.RESET_VALUE(btcc_pkg::ONE_BCD)) u_month (
    .hclk(hclk), .hresetn(hresetn), .inc(day_carry), .load(wr_date),
    .load_value(hwdata[btcc_pkg::MONTH_LSB +: 8]), .min_value(btcc_pkg::ONE_BCD),
    .max_value(btcc_pkg::MONTH_MAX), .value(month), .carry(month_carry)
  );
  btcc_bcd_field #(.RESET_VALUE(btcc_pkg::ZERO_BCD)) u_year (
    .hclk(hclk), .hresetn(hresetn), .inc(month_carry), .load(wr_date),
    .load_value(hwdata[btcc_pkg::YEAR_LSB +: 8]), .min_value(btcc_pkg::ZERO_BCD),
    .max_value(btcc_pkg::YEAR_MAX), .value(year), .carry()
  );

  // leap years are BCD multiples of four
  assign leap = !year[0] && (year[1] == year[4]);

  always_comb begin
    unique case (month)
      btcc_pkg::FEB: day_max = leap ? btcc_pkg::DAYS_29 : btcc_pkg::DAYS_28;
      btcc_pkg::APR, btcc_pkg::JUN, btcc_pkg::SEP, btcc_pkg::NOV: begin
        day_max = btcc_pkg::DAYS_30;
      end
      default: day_max = btcc_pkg::DAYS_31;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign gated = s.idle_halt && cpu_idle;
  assign accept = hsel && htrans[1] && hready;
  assign wr_go = s.pending && s.write && !s.applied && !gated;
  assign wr_ctrl = wr_go && (s.addr == btcc_pkg::CTRL_OFFSET);
  assign wr_alarm = wr_go && (s.addr == btcc_pkg::ALARM_OFFSET);
  assign wr_time = wr_go && (s.addr == btcc_pkg::TIME_OFFSET) && s.unlock;
  assign wr_date = wr_go && (s.addr == btcc_pkg::DATE_OFFSET) && s.unlock;

  assign hreadyout = !s.pending || (!gated && (!s.write || s.applied));
  assign hrdata = s.rdata;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Tick generation

  // crystal pulses counted per half second
  assign run_tick = crystal_rise && s.enable;
  assign half_tick = run_tick && (s.prescaler == btcc_pkg::HALF_TERMINAL);
  assign sec_tick = half_tick && s.half_phase;
  // sign extension covers plus 511 to minus 512
  assign trim_ext = {{6{s.trim[9]}}, s.trim};
  assign warn = s.enable && !s.prescaler[15] && (s.prescaler >= btcc_pkg::WARN_START);

  ////////////////////////////////////////////////////////////////////////////
  // Alarm interval decode

  always_comb begin
    unique case (s.interval)
      btcc_pkg::INT_HALF: interval_hit = half_tick;
      btcc_pkg::INT_SEC: interval_hit = sec_tick;
      btcc_pkg::INT_TEN_SEC: interval_hit = sec_tick && (sec[3:0] == btcc_pkg::DIGIT_NINE);
      btcc_pkg::INT_MIN: interval_hit = sec_carry;
      btcc_pkg::INT_TEN_MIN: interval_hit = sec_carry && (min[3:0] == btcc_pkg::DIGIT_NINE);
      btcc_pkg::INT_HOUR: interval_hit = min_carry;
      btcc_pkg::INT_DAY: interval_hit = hour_carry;
      btcc_pkg::INT_WEEK: interval_hit = hour_carry && (wday == btcc_pkg::WDAY_MAX);
      btcc_pkg::INT_MONTH: interval_hit = day_carry;
      btcc_pkg::INT_YEAR: interval_hit = month_carry;
      default: interval_hit = 1'b0;
    endcase
  end

  // alarm fires on the chosen interval
  assign alarm_event = s.arm && interval_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;
    // Bus phases
    if (accept) begin
      next_s.pending = 1'b1;
      next_s.write = hwrite;
      next_s.applied = 1'b0;
      next_s.addr = haddr[7:0];
      unique case (haddr[7:0])
        btcc_pkg::CTRL_OFFSET: begin
          next_s.rdata = '0;
          next_s.rdata[btcc_pkg::TRIM_MSB:btcc_pkg::TRIM_LSB] = s.trim;
          next_s.rdata[btcc_pkg::ENABLE_BIT] = s.enable;
          next_s.rdata[btcc_pkg::IDLE_HALT_BIT] = s.idle_halt;
          next_s.rdata[btcc_pkg::SRC_SEL_BIT] = s.src_sel;
          next_s.rdata[btcc_pkg::RUNNING_BIT] = s.running && s.enable;
          next_s.rdata[btcc_pkg::UNLOCK_BIT] = s.unlock;
          next_s.rdata[btcc_pkg::WARN_BIT] = warn;
          next_s.rdata[btcc_pkg::HALF_BIT] = s.half_phase;
          next_s.rdata[btcc_pkg::PIN_OE_BIT] = s.pin_oe_bit;
        end
        btcc_pkg::ALARM_OFFSET: begin
          next_s.rdata = '0;
          next_s.rdata[btcc_pkg::ARM_BIT] = s.arm;
          next_s.rdata[btcc_pkg::CHIME_BIT] = s.chime;
          next_s.rdata[btcc_pkg::PULSE_BIT] = s.pulse;
          next_s.rdata[btcc_pkg::ALARM_SYNC_BIT] = warn;
          next_s.rdata[btcc_pkg::INTERVAL_MSB:btcc_pkg::INTERVAL_LSB] = s.interval;
          next_s.rdata[7:0] = s.repeat_count;
        end
        btcc_pkg::TIME_OFFSET: next_s.rdata = {hour, min, sec, 8'h00};
        btcc_pkg::DATE_OFFSET: next_s.rdata = {year, month, day, wday};
        default: next_s.rdata = '0;
      endcase
    end else if (s.pending && hreadyout) begin
      next_s.pending = 1'b0;
    end
    if (wr_go) begin
      next_s.applied = 1'b1;
    end
    // Control writes
    if (wr_ctrl) begin
      next_s.trim = hwdata[btcc_pkg::TRIM_MSB:btcc_pkg::TRIM_LSB];
      next_s.idle_halt = hwdata[btcc_pkg::IDLE_HALT_BIT];
      next_s.src_sel = hwdata[btcc_pkg::SRC_SEL_BIT];
      next_s.pin_oe_bit = hwdata[btcc_pkg::PIN_OE_BIT];
      if (s.unlock) begin
        next_s.enable = hwdata[btcc_pkg::ENABLE_BIT];
      end
      next_s.unlock = hwdata[btcc_pkg::UNLOCK_BIT] && (s.unlock || system_unlock);
    end
    // Half-second prescaler and phase
    if (wr_time) begin
      next_s.prescaler = '0;
      next_s.half_phase = 1'b0;
    end else if (run_tick) begin
      if (half_tick) begin
        next_s.prescaler = (sec_tick && sec == btcc_pkg::SEC_MAX) ? trim_ext : '0;
        next_s.half_phase = !s.half_phase;
      end else begin
        next_s.prescaler = s.prescaler + 16'h0001;
      end
    end
    // Crystal activity watchdog
    if (crystal_rise) begin
      next_s.idle_count = '0;
      next_s.running = 1'b1;
    end else if (s.idle_count == 16'(CLOCK_TIMEOUT_CYCLES)) begin
      next_s.running = 1'b0;
    end else begin
      next_s.idle_count = s.idle_count + 16'h0001;
    end
    // Alarm; software writes win over hardware updates
    if (wr_alarm) begin
      next_s.arm = hwdata[btcc_pkg::ARM_BIT];
      next_s.chime = hwdata[btcc_pkg::CHIME_BIT];
      next_s.interval = hwdata[btcc_pkg::INTERVAL_MSB:btcc_pkg::INTERVAL_LSB];
      next_s.repeat_count = hwdata[7:0];
      if (!s.arm) begin
        next_s.pulse = hwdata[btcc_pkg::PULSE_BIT];
      end
    end else if (alarm_event) begin
      next_s.pulse = !s.pulse;
      if (s.repeat_count != 8'h00) begin
        next_s.repeat_count = s.repeat_count - 8'h01;
      end else if (s.chime) begin
        next_s.repeat_count = btcc_pkg::REPEAT_WRAP;
      end else begin
        next_s.arm = 1'b0;
      end
    end
    next_s.pin = s.pin_oe_bit && (s.src_sel ? s.half_phase : s.pulse);
    next_s.pin_drive = s.pin_oe_bit;
    // Non-power-on resets clear only the bus phase
    if (sys_reset) begin
      next_s.pending = 1'b0;
      next_s.applied = 1'b0;
    end
  end

  // control cleared only by power-on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign timekeeper_pin = s.pin;
  assign timekeeper_pin_oe = s.pin_drive;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  enable_lock_a: assert property (wr_ctrl && !s.unlock |=> $stable(s.enable))
    else $error("enable changed while locked");
  unlock_gate_a: assert property ($rose(s.unlock) |-> $past(system_unlock))
    else $error("unlock set without system unlock");
  pin_gate_a: assert property (!s.pin_oe_bit |=> !timekeeper_pin && !timekeeper_pin_oe)
    else $error("pin driven while output disabled");
  pin_source_a: assert property (s.pin_oe_bit && s.src_sel |=> timekeeper_pin == $past(s.half_phase))
    else $error("pin not showing seconds clock");
  half_clear_a: assert property (wr_time |=> !s.half_phase && s.prescaler == 16'h0000)
    else $error("half phase not cleared by time write");
  trim_load_a: assert property (sec_tick && sec == btcc_pkg::SEC_MAX && !wr_time |=> s.prescaler == $past(trim_ext))
    else $error("trim not loaded at minute");
  chime_wrap_a: assert property (alarm_event && s.chime && s.repeat_count == 8'h00 && !wr_alarm
    |=> s.repeat_count == btcc_pkg::REPEAT_WRAP)
    else $error("repeat count did not wrap");
  arm_clear_a: assert property (alarm_event && !s.chime && s.repeat_count == 8'h00 && !wr_alarm
    |=> !s.arm ##1 !s.arm)
    else $error("arm not cleared after last alarm");
  time_lock_a: assert property (wr_go && s.addr == btcc_pkg::TIME_OFFSET && !s.unlock && !sec_tick
    |=> $stable(sec) && $stable(min) && $stable(hour))
    else $error("time changed by locked write");
  warn_half_a: assert property (half_tick |-> $past(warn))
    else $error("rollover without warning");

  alarm_fire_c: cover property (alarm_event);
  minute_roll_c: cover property (sec_carry && s.trim != 10'h000);
  idle_stall_c: cover property (s.pending && gated);
  time_write_c: cover property (wr_time);

endmodule

// ---- testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] A_CTRL = {24'h00_0000, btcc_pkg::CTRL_OFFSET};
  localparam logic [31:0] A_ALARM = {24'h00_0000, btcc_pkg::ALARM_OFFSET};
  localparam logic [31:0] A_TIME = {24'h00_0000, btcc_pkg::TIME_OFFSET};
  localparam logic [31:0] A_DATE = {24'h00_0000, btcc_pkg::DATE_OFFSET};

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic sys_reset = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic crystal_in = 1'b0;
  logic xtal_run = 1'b1;
  logic system_unlock = 1'b0;
  logic cpu_idle = 1'b0;
  logic timekeeper_pin;
  logic timekeeper_pin_oe;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  btcc_timekeeper #(.CLOCK_TIMEOUT_CYCLES(50)) btcc_timekeeper_i (
    .hclk(hclk), .hresetn(hresetn), .sys_reset(sys_reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .crystal_in(crystal_in),
    .system_unlock(system_unlock), .cpu_idle(cpu_idle), .timekeeper_pin(timekeeper_pin),
    .timekeeper_pin_oe(timekeeper_pin_oe)
  );

  initial begin
    forever #2 hclk = ~hclk;
  end

  // Crystal toggles on falling bus clock edges; stands low while stopped
  always #8 crystal_in <= xtal_run ? ~crystal_in : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single transfer; waits on hready for both phases
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0000_0000, x);
    check(x, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(A_CTRL, 32'h0000_0000);
    rd_chk(A_ALARM, 32'h0000_0000);
    rd_chk(A_TIME, 32'h0000_0000);
    rd_chk(A_DATE, 32'h0001_0100);
    $display("test reset done");
  endtask

  task automatic t_lock();
    wr(A_TIME, 32'h1234_5600);
    rd_chk(A_TIME, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_8008);
    rd_chk(A_CTRL, 32'h0000_0000);
    $display("test lock done");
  endtask

  task automatic t_unlock();
    system_unlock <= 1'b1;
    wr(A_CTRL, 32'h0000_0008);
    rd_chk(A_CTRL, 32'h0000_0008);
    wr(A_TIME, 32'h2359_4500);
    rd_chk(A_TIME, 32'h2359_4500);
    wr(A_DATE, 32'h9912_3106);
    rd_chk(A_DATE, 32'h9912_3106);
    $display("test unlock done");
  endtask

  task automatic t_trim();
    wr(A_CTRL, 32'h0200_8008);
    repeat (30) @(posedge hclk);
    rd_chk(A_CTRL, 32'h0200_8048);
    wr(A_CTRL, 32'h01ff_8008);
    repeat (30) @(posedge hclk);
    rd_chk(A_CTRL, 32'h01ff_8048);
    $display("test trim done");
  endtask

  task automatic t_pin();
    wr(A_ALARM, 32'h0000_4905);
    rd_chk(A_ALARM, 32'h0000_4905);
    wr(A_ALARM, 32'h0000_2000);
    wr(A_CTRL, 32'h0000_8009);
    repeat (3) @(posedge hclk);
    check({30'h0, timekeeper_pin_oe, timekeeper_pin}, 32'h0000_0003);
    wr(A_CTRL, 32'h0000_8089);
    repeat (3) @(posedge hclk);
    check({30'h0, timekeeper_pin_oe, timekeeper_pin}, 32'h0000_0002);
    wr(A_CTRL, 32'h0000_8008);
    repeat (3) @(posedge hclk);
    check({30'h0, timekeeper_pin_oe, timekeeper_pin}, 32'h0000_0000);
    $display("test pin done");
  endtask

  task automatic t_idle();
    wr(A_CTRL, 32'h0000_a008);
    cpu_idle <= 1'b1;
    fork
      rd_chk(A_CTRL, 32'h0000_a048);
      begin
        repeat (6) @(posedge hclk);
        check({31'h0, hreadyout}, 32'h0000_0000);
        cpu_idle <= 1'b0;
      end
    join
    wr(A_CTRL, 32'h0000_8008);
    cpu_idle <= 1'b1;
    rd_chk(A_CTRL, 32'h0000_8048);
    cpu_idle <= 1'b0;
    $display("test idle done");
  endtask

  task automatic t_misc();
    sys_reset <= 1'b1;
    repeat (2) @(posedge hclk);
    sys_reset <= 1'b0;
    rd_chk(A_CTRL, 32'h0000_8048);
    xtal_run <= 1'b0;
    repeat (100) @(posedge hclk);
    rd_chk(A_CTRL, 32'h0000_8008);
    wr(32'h0000_0010, 32'hffff_ffff);
    check({31'h0, hresp}, 32'h0000_0000);
    rd_chk(32'h0000_0010, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_8000);
    wr(A_TIME, 32'h0000_0000);
    rd_chk(A_TIME, 32'h2359_4500);
    rd_chk(A_CTRL, 32'h0000_8000);
    $display("test misc done");
  endtask

  // One half-second rollover with a chiming alarm on every half second
  task automatic t_half();
    xtal_run <= 1'b1;
    wr(A_CTRL, 32'h0000_8008);
    wr(A_ALARM, 32'h0000_c000);
    wr(A_CTRL, 32'h0000_8089);
    wr(A_TIME, 32'h2359_4500);
    while (timekeeper_pin !== 1'b1) begin
      @(posedge hclk);
    end
    rd_chk(A_ALARM, 32'h0000_e0ff);
    rd_chk(A_CTRL, 32'h0000_80cb);
    rd_chk(A_TIME, 32'h2359_4500);
    rd_chk(A_TIME, 32'h2359_4500);
    wr(A_CTRL, 32'h0000_0008);
    repeat (2) @(posedge hclk);
    rd_chk(A_CTRL, 32'h0000_000a);
    $display("test half second done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_lock();
    t_unlock();
    t_trim();
    t_pin();
    t_idle();
    t_misc();
    t_half();
    final_report();
  end
endmodule
